//--- core/acc_params.svh
`ifndef ACC_PARAMS_SVH
`define ACC_PARAMS_SVH

// Resolution of a full conversion and of the reduced mode.
`define ACC_RES_BITS 10
`define ACC_RES8_BITS 8
// Index of the last bit resolved in each mode.
`define ACC_LAST_BIT_10 4'h0
`define ACC_LAST_BIT_8 4'h2
// Trial code loaded at the start of a conversion (MSB set).
`define ACC_SAR_START 10'h200
// Width of the conversion clock divider field.
`define ACC_DIV_BITS 5
// Reset value of the divider field counter.
`define ACC_DIV_RESET 5'h00
// Reset value of both result bytes.
`define ACC_RESULT_RESET 8'h00
// Start-mode codes, three bits.
`define ACC_SM_SOFT 3'h0
`define ACC_SM_TMR0 3'h1
`define ACC_SM_TMR2 3'h2
`define ACC_SM_TMR1 3'h3
`define ACC_SM_EXT 3'h4
`define ACC_SM_TMR3 3'h5
// Throughput target and clock period, in nanoseconds.
`define ACC_SAMPLE_PERIOD_NS 2000
`define ACC_CLK_PERIOD_NS 20
// System clocks available for one conversion at peak throughput.
`define ACC_SAMPLE_CYC (`ACC_SAMPLE_PERIOD_NS / `ACC_CLK_PERIOD_NS)

`endif

//--- core/acc_pkg.sv
package acc_pkg;

    // Conversion sequencer states.
    typedef enum logic [1:0] {
        ACC_IDLE,
        ACC_TRACK,
        ACC_CONVERT
    } acc_state_t;

    // Bit index inside the ten-bit trial code.
    typedef logic [3:0] acc_bit_idx_t;

endpackage

//--- core/acc_prescaler.sv
`timescale 1ns/100ps
`include "acc_params.svh"

// Divides the system clock into one-cycle conversion clock ticks.
module acc_prescaler
    import acc_pkg::*;
(
    input wire logic mclk_i,
    input wire logic resetn_i,
    input wire logic ce_i,
    input wire logic restart_i,
    input wire logic [`ACC_DIV_BITS-1:0] divider_i,
    output logic tick_o
);

    logic [`ACC_DIV_BITS-1:0] cnt_r; // Cycles left before the next tick.
    logic [`ACC_DIV_BITS-1:0] cnt_nxt;
    logic tick_r; // Registered tick pulse.
    logic tick_nxt;

    // Count down from the divider value; a tick every divider+1 cycles.
    always_comb begin
        cnt_nxt = cnt_r;
        tick_nxt = 1'b0;
        if (restart_i) begin
            // Restart aligns the first tick to the conversion start.
            cnt_nxt = divider_i;
        end else if (cnt_r == `ACC_DIV_RESET) begin
            cnt_nxt = divider_i;
            tick_nxt = 1'b1;
        end else begin
            cnt_nxt = cnt_r - 1'b1;
        end
    end

    // Register the divider state.
    always_ff @(posedge mclk_i) begin
        if (!resetn_i) begin
            cnt_r <= `ACC_DIV_RESET;
            tick_r <= 1'b0;
        end else if (ce_i) begin
            cnt_r <= cnt_nxt;
            tick_r <= tick_nxt;
        end
    end

    assign tick_o = tick_r;

endmodule // acc_prescaler

//--- core/acc_start_sel.sv
`timescale 1ns/100ps
`include "acc_params.svh"

// Picks the start source and turns it into one start pulse.
module acc_start_sel
    import acc_pkg::*;
(
    input wire logic mclk_i,
    input wire logic resetn_i,
    input wire logic ce_i,
    input wire logic [2:0] start_mode_select_i,
    input wire logic busy_write_i,
    input wire logic timer0_ovf_i,
    input wire logic timer1_ovf_i,
    input wire logic timer2_lo_ovf_i,
    input wire logic timer2_hi_ovf_i,
    input wire logic timer2_split_i,
    input wire logic timer3_lo_ovf_i,
    input wire logic timer3_hi_ovf_i,
    input wire logic timer3_split_i,
    input wire logic external_start_input_i,
    output logic start_o
);

    logic ext_prev_r; // Last sampled level of the external start input.
    logic start_r; // Registered start request.
    logic start_nxt;

    // Select one of the six sources.
    always_comb begin
        start_nxt = 1'b0;
        // codes 000 to 101, in order.
        unique case (start_mode_select_i)
            `ACC_SM_SOFT: start_nxt = busy_write_i;
            `ACC_SM_TMR0: start_nxt = timer0_ovf_i;
            `ACC_SM_TMR2: start_nxt = timer2_split_i ? timer2_lo_ovf_i
                                                     : timer2_hi_ovf_i;
            `ACC_SM_TMR1: start_nxt = timer1_ovf_i;
            `ACC_SM_EXT: start_nxt = external_start_input_i & ~ext_prev_r;
            `ACC_SM_TMR3: start_nxt = timer3_split_i ? timer3_lo_ovf_i
                                                     : timer3_hi_ovf_i;
            // Codes 110 and 111 start nothing.
            default: start_nxt = 1'b0;
        endcase
    end

    // Register the request and the edge history.
    always_ff @(posedge mclk_i) begin
        if (!resetn_i) begin
            ext_prev_r <= 1'b0;
            start_r <= 1'b0;
        end else if (ce_i) begin
            ext_prev_r <= external_start_input_i;
            start_r <= start_nxt;
        end
    end

    assign start_o = start_r;

endmodule // acc_start_sel

//--- core/acc_core.sv
`timescale 1ns/100ps
`include "acc_params.svh"

module acc_core
    import acc_pkg::*;
(
    // Clock, reset and the freeze enable.
    input wire logic mclk_i,
    input wire logic resetn_i,
    input wire logic ce_i,
    // Result format, resolution and conversion clock.
    input wire logic left_justify_bit_i,
    input wire logic eight_bit_mode_bit_i,
    input wire logic [`ACC_DIV_BITS-1:0] conv_clock_divider_i,
    // Start selection, software strobes and enable.
    input wire logic [2:0] start_mode_select_i,
    input wire logic busy_write_i,
    input wire logic done_clear_i,
    input wire logic int_enable_i,
    // Timer overflow pulses and timer split modes.
    input wire logic timer0_ovf_i,
    input wire logic timer1_ovf_i,
    input wire logic timer2_lo_ovf_i,
    input wire logic timer2_hi_ovf_i,
    input wire logic timer2_split_i,
    input wire logic timer3_lo_ovf_i,
    input wire logic timer3_hi_ovf_i,
    input wire logic timer3_split_i,
    // External start pin.
    input wire logic external_start_input_i,
    // Comparator verdict on the current trial code.
    input wire logic comparator_i,
    // Status flags and the two result bytes.
    output logic conversion_busy_bit_o,
    output logic conversion_done_flag_o,
    output logic irq_o,
    output logic [7:0] result_high_byte_o,
    output logic [7:0] result_low_byte_o,
    // Trial code and sampling phase for the analog side.
    output logic [`ACC_RES_BITS-1:0] sar_trial_o,
    output logic track_o
);

    // Mask with only the given bit of the trial code set.
    function automatic logic [`ACC_RES_BITS-1:0] bit_mask(
        input acc_bit_idx_t idx
    );
        // Index 9 is the MSB and index 0 the LSB.
        bit_mask = {{(`ACC_RES_BITS-1){1'b0}}, 1'b1} << idx;
    endfunction

    // Links between the sub-blocks.
    logic start_pulse; // One-cycle start request from the selector.
    logic conv_tick; // One-cycle conversion clock tick.
    logic tick_restart; // Realigns the prescaler at a start.

    // Sequencer state and its next values.
    acc_state_t state_r; // Sequencer state.
    acc_state_t state_nxt;
    logic [`ACC_RES_BITS-1:0] sar_r; // Trial code shown to the comparator.
    logic [`ACC_RES_BITS-1:0] sar_nxt;
    acc_bit_idx_t bit_r; // Bit being resolved.
    acc_bit_idx_t bit_nxt;

    // Resolution and busy for the running conversion.
    logic mode8_r; // Resolution latched for the running conversion.
    logic mode8_nxt;
    logic busy_r; // Busy flag.
    logic busy_nxt;

    // Decodes of the current cycle.
    logic finish; // Last bit resolved this cycle.
    logic [`ACC_RES_BITS-1:0] final_code; // Code once the last bit settles.

    // Flags and results, loaded at finish.
    logic done_r; // Conversion-complete flag.
    logic done_nxt;
    logic irq_r; // Interrupt request.
    logic irq_nxt;
    logic [7:0] res_hi_r; // High result byte.
    logic [7:0] res_hi_nxt;
    logic [7:0] res_lo_r; // Low result byte.
    logic [7:0] res_lo_nxt;

    acc_start_sel u_start_sel (
        .mclk_i(mclk_i),
        .resetn_i(resetn_i),
        .ce_i(ce_i),
        .start_mode_select_i(start_mode_select_i),
        .busy_write_i(busy_write_i),
        .timer0_ovf_i(timer0_ovf_i),
        .timer1_ovf_i(timer1_ovf_i),
        .timer2_lo_ovf_i(timer2_lo_ovf_i),
        .timer2_hi_ovf_i(timer2_hi_ovf_i),
        .timer2_split_i(timer2_split_i),
        .timer3_lo_ovf_i(timer3_lo_ovf_i),
        .timer3_hi_ovf_i(timer3_hi_ovf_i),
        .timer3_split_i(timer3_split_i),
        .external_start_input_i(external_start_input_i),
        .start_o(start_pulse)
    );

    // The prescaler restarts whenever the sequencer is idle, so every
    // conversion sees the same number of system clocks per SAR clock.
    assign tick_restart = (state_r == ACC_IDLE);

    acc_prescaler u_prescaler (
        .mclk_i(mclk_i),
        .resetn_i(resetn_i),
        .ce_i(ce_i),
        .restart_i(tick_restart),
        .divider_i(conv_clock_divider_i),
        .tick_o(conv_tick)
    );

    // divider 7 or less fits 100 clocks.
    // The last bit is done when the tick lands on the mode's final index.
    // Between ticks the bit under test stays put.
    assign finish = (state_r == ACC_CONVERT) && conv_tick &&
                    (bit_r == (mode8_r ? `ACC_LAST_BIT_8
                                       : `ACC_LAST_BIT_10));

    // Trial code with the current bit kept or dropped by the comparator.
    // The comparator is read in the tick cycle itself.
    assign final_code = comparator_i ? sar_r : (sar_r & ~bit_mask(bit_r));

    // Sequencer: one track tick, then one tick per resolved bit.
    always_comb begin
        state_nxt = state_r;
        sar_nxt = sar_r;
        bit_nxt = bit_r;
        mode8_nxt = mode8_r;
        busy_nxt = busy_r;

        unique case (state_r)
            ACC_IDLE: begin
                // start on demand.
                // Starts that arrive while busy are dropped on purpose;
                // a retrigger would corrupt the code being resolved.
                if (start_pulse) begin
                    state_nxt = ACC_TRACK;
                    mode8_nxt = eight_bit_mode_bit_i;
                    sar_nxt = `ACC_SAR_START;
                    bit_nxt = acc_bit_idx_t'(`ACC_RES_BITS - 1);
                    busy_nxt = 1'b1;
                end
            end

            ACC_TRACK: begin
                // One SAR clock lets the trial code settle.
                if (conv_tick) begin
                    state_nxt = ACC_CONVERT;
                end
            end

            ACC_CONVERT: begin
                if (conv_tick) begin
                    // Keep or drop the bit under test.
                    sar_nxt = final_code;
                    if (finish) begin
                        state_nxt = ACC_IDLE;
                        busy_nxt = 1'b0;
                    end else begin
                        bit_nxt = bit_r - 1'b1;
                        // The next bit becomes the new trial.
                        sar_nxt = final_code | bit_mask(bit_r - 1'b1);
                    end
                end
            end

            // An illegal state code falls back to idle.
            default: begin
                state_nxt = ACC_IDLE;
                busy_nxt = 1'b0;
            end
        endcase
    end

    // Register the sequencer.
    always_ff @(posedge mclk_i) begin
        if (!resetn_i) begin
            // Reset parks the sequencer idle.
            state_r <= ACC_IDLE;
            sar_r <= {`ACC_RES_BITS{1'b0}};
            bit_r <= acc_bit_idx_t'(`ACC_RES_BITS - 1);
            mode8_r <= 1'b0;
            busy_r <= 1'b0;
        end else if (ce_i) begin
            // A low enable holds the whole sequencer.
            state_r <= state_nxt;
            sar_r <= sar_nxt;
            bit_r <= bit_nxt;
            mode8_r <= mode8_nxt;
            busy_r <= busy_nxt;
        end
    end

    // Result formatting, done flag and interrupt request.
    always_comb begin
        res_hi_nxt = res_hi_r;
        res_lo_nxt = res_lo_r;
        done_nxt = done_r;
        if (done_clear_i) begin
            done_nxt = 1'b0;
        end

        if (finish) begin
            // busy fall sets the flag; set beats a same-cycle clear.
            done_nxt = 1'b1;
            // results loaded together with the flag.
            if (mode8_r) begin
                // eight MSBs in the high byte.
                res_hi_nxt = final_code[9:2];
                res_lo_nxt = `ACC_RESULT_RESET;
            end else if (left_justify_bit_i) begin
                res_hi_nxt = final_code[9:2];
                res_lo_nxt = {final_code[1:0], 6'h00};
            end else begin
                res_hi_nxt = {6'h00, final_code[9:8]};
                res_lo_nxt = final_code[7:0];
            end
        end

        // request follows the flag when enabled.
        // A level, so it drops in the cycle the flag clears.
        irq_nxt = done_nxt & int_enable_i;
    end

    // Register the result bytes and flags.
    always_ff @(posedge mclk_i) begin
        if (!resetn_i) begin
            // Reset empties both bytes and both flags.
            res_hi_r <= `ACC_RESULT_RESET;
            res_lo_r <= `ACC_RESULT_RESET;
            done_r <= 1'b0;
            irq_r <= 1'b0;
        end else if (ce_i) begin
            // A low enable freezes results and flags.
            res_hi_r <= res_hi_nxt;
            res_lo_r <= res_lo_nxt;
            done_r <= done_nxt;
            irq_r <= irq_nxt;
        end
    end

    // The track output is a decode of the next state, one flop deep.
    logic track_r; // Sampling phase indicator.
    logic track_nxt;

    // Tracking is the state the sequencer moves into next.
    always_comb begin
        track_nxt = (state_nxt == ACC_TRACK);
    end

    // Register the tracking phase.
    always_ff @(posedge mclk_i) begin
        if (!resetn_i) begin
            track_r <= 1'b0;
        end else if (ce_i) begin
            track_r <= track_nxt;
        end
    end

    // Every output comes straight from a register.
    assign conversion_busy_bit_o = busy_r;
    assign conversion_done_flag_o = done_r;
    assign irq_o = irq_r;
    assign result_high_byte_o = res_hi_r;
    assign result_low_byte_o = res_lo_r;
    assign sar_trial_o = sar_r;
    assign track_o = track_r;

endmodule // acc_core

//--- verification/acc_analog_model.sv
`timescale 1ns/100ps

// Analog side of the converter: a sample-and-hold and one comparator.
module acc_analog_model (
    input wire logic mclk_i,
    input wire logic resetn_i,
    input wire logic track_i,
    input wire logic [9:0] level_i,
    input wire logic [9:0] sar_trial_i,
    output logic comparator_o
);
    // Held input level; it follows the input only while tracking or in reset.
    logic [9:0] held_r;

    // Reset also loads it, so the comparator never shows an unknown.
    always_ff @(posedge mclk_i) begin
        if (!resetn_i || track_i) begin
            held_r <= level_i;
        end
    end

    // High while the held level reaches the trial code, as a real one.
    assign comparator_o = (held_r >= sar_trial_i);
endmodule // acc_analog_model

//--- verification/acc_core_properties.sv
`timescale 1ns/100ps
`include "acc_params.svh"

// Watches the core's ports for flag, start and timing slips.
module acc_chk (
    input wire logic mclk_i,
    input wire logic resetn_i,
    input wire logic ce_i,
    input wire logic eight_bit_mode_bit_i,
    input wire logic [`ACC_DIV_BITS-1:0] conv_clock_divider_i,
    input wire logic [2:0] start_mode_select_i,
    input wire logic busy_write_i,
    input wire logic done_clear_i,
    input wire logic int_enable_i,
    input wire logic timer0_ovf_i,
    input wire logic timer1_ovf_i,
    input wire logic timer2_lo_ovf_i,
    input wire logic timer2_hi_ovf_i,
    input wire logic timer2_split_i,
    input wire logic timer3_lo_ovf_i,
    input wire logic timer3_hi_ovf_i,
    input wire logic timer3_split_i,
    input wire logic external_start_input_i,
    input wire logic conversion_busy_bit_o,
    input wire logic conversion_done_flag_o,
    input wire logic irq_o,
    input wire logic [7:0] result_high_byte_o,
    input wire logic [7:0] result_low_byte_o
);
    // Last external level, busy length counter, resolution at start.
    logic ext_q_r, ext_q_nxt, e8_r, e8_nxt;
    logic [9:0] cnt_r, cnt_nxt, exp_len;
    // Request from the selected source in this cycle.
    logic fire;

    always_comb begin
        case (start_mode_select_i)
            `ACC_SM_SOFT: fire = busy_write_i;
            `ACC_SM_TMR0: fire = timer0_ovf_i;
            `ACC_SM_TMR2: fire = timer2_split_i ? timer2_lo_ovf_i
                                                : timer2_hi_ovf_i;
            `ACC_SM_TMR1: fire = timer1_ovf_i;
            `ACC_SM_EXT: fire = external_start_input_i && !ext_q_r;
            `ACC_SM_TMR3: fire = timer3_split_i ? timer3_lo_ovf_i
                                                : timer3_hi_ovf_i;
            default: fire = 1'b0;
        endcase
        // Frozen cycles neither count nor move the edge memory.
        ext_q_nxt = ce_i ? external_start_input_i : ext_q_r;
        e8_nxt = (ce_i && !conversion_busy_bit_o) ? eight_bit_mode_bit_i
                                                   : e8_r;
        cnt_nxt = !ce_i ? cnt_r : (conversion_busy_bit_o ? cnt_r + 10'h001
                                                         : 10'h000);
        exp_len = (e8_r ? 10'h009 : 10'h00B)
                  * ({5'h00, conv_clock_divider_i} + 10'h001);
    end

    // Registers the helper state only.
    always_ff @(posedge mclk_i) begin
        if (!resetn_i) begin
            ext_q_r <= 1'b0;
            e8_r <= 1'b0;
            cnt_r <= 10'h000;
        end else begin
            ext_q_r <= ext_q_nxt;
            e8_r <= e8_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!resetn_i);

    AST_DONE_ON_FALL: assert property (
        $fell(conversion_busy_bit_o) && $past(resetn_i)
        |-> conversion_done_flag_o)
        else $error("done flag missing when busy fell");
    AST_DONE_CAUSE: assert property (
        $rose(conversion_done_flag_o) |-> $fell(conversion_busy_bit_o))
        else $error("done flag rose without busy falling");
    AST_DONE_STICKY: assert property (
        conversion_done_flag_o && !done_clear_i |=> conversion_done_flag_o)
        else $error("done flag dropped without a clear");
    AST_DONE_CLEAR: assert property (
        done_clear_i && ce_i && !conversion_busy_bit_o
        |=> !conversion_done_flag_o)
        else $error("done flag survived a clear");
    AST_IRQ_LEVEL: assert property (
        ce_i |=> irq_o == (conversion_done_flag_o
                           && $past(int_enable_i)))
        else $error("irq does not follow done and enable");
    AST_UNUSED_ZERO: assert property (
        result_high_byte_o[7:2] == 6'h00 || result_low_byte_o[5:0] == 6'h00)
        else $error("unused result bits not zero");
    AST_START_SRC: assert property (
        ce_i && fire && !conversion_busy_bit_o ##1 ce_i
        |-> ##1 conversion_busy_bit_o)
        else $error("selected source did not start");
    AST_NO_STRAY: assert property (
        $rose(conversion_busy_bit_o) && $past(ce_i) && $past(ce_i, 2)
        |-> $past(fire, 2))
        else $error("busy rose without a selected source");
    AST_BUSY_LEN: assert property (
        $fell(conversion_busy_bit_o) && $past(resetn_i)
        |-> cnt_r + 10'h002 >= exp_len && cnt_r <= exp_len + 10'h002)
        else $error("conversion length off for divider");
endmodule // acc_chk

//--- verification/tb_adc_conversion_control.sv
`timescale 1ns/100ps
`include "acc_params.svh"

// Self-checking bench: starts conversions and checks result and flags.
module tb_adc_conversion_control;
    // Design inputs, all but comparator_i driven at the falling edge.
    logic mclk_i = 1'b0;
    logic resetn_i, ce_i, left_justify_bit_i, eight_bit_mode_bit_i;
    logic [`ACC_DIV_BITS-1:0] conv_clock_divider_i;
    logic [2:0] start_mode_select_i;
    logic busy_write_i, done_clear_i, int_enable_i, timer0_ovf_i;
    logic timer1_ovf_i, timer2_lo_ovf_i, timer2_hi_ovf_i, timer2_split_i;
    logic timer3_lo_ovf_i, timer3_hi_ovf_i, timer3_split_i;
    logic external_start_input_i, comparator_i;
    // Design outputs.
    logic conversion_busy_bit_o, conversion_done_flag_o, irq_o, track_o;
    logic [7:0] result_high_byte_o, result_low_byte_o;
    logic [9:0] sar_trial_o;
    // Analog level, the stall request and the bookkeeping.
    logic [9:0] level = 10'h000;
    logic stall = 1'b0;
    int n_fail = 0;
    int tests_run = 0;
    int cyc = 0;
    int len, len10, len8;

    acc_core dut_u (.mclk_i, .resetn_i, .ce_i, .left_justify_bit_i,
        .eight_bit_mode_bit_i, .conv_clock_divider_i, .start_mode_select_i,
        .busy_write_i, .done_clear_i, .int_enable_i, .timer0_ovf_i,
        .timer1_ovf_i, .timer2_lo_ovf_i, .timer2_hi_ovf_i, .timer2_split_i,
        .timer3_lo_ovf_i, .timer3_hi_ovf_i, .timer3_split_i,
        .external_start_input_i, .comparator_i, .conversion_busy_bit_o,
        .conversion_done_flag_o, .irq_o, .result_high_byte_o,
        .result_low_byte_o, .sar_trial_o, .track_o);
    acc_analog_model ana_u (.mclk_i, .resetn_i, .track_i(track_o),
        .level_i(level), .sar_trial_i(sar_trial_o),
        .comparator_o(comparator_i));

    // Half period of 10 ns gives the 50 MHz system clock.
    always #10 mclk_i = ~mclk_i;

    // Cuts a hung run short; the full run needs far fewer cycles.
    always @(posedge mclk_i) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            n_fail++;
            end_of_test();
        end
    end

    // Compares a result word; case inequality lets no unknown pass.
    task automatic chk_val(input logic [15:0] g, input logic [15:0] e,
            input string what);
        tests_run++;
        if (g !== e) begin
            n_fail++;
            $display("unexpected at %0t: %s got %h want %h", $time, what,
                g, e);
        end
    endtask

    // Compares a single flag.
    task automatic chk_bit(input logic g, input logic e, input string what);
        chk_val({15'h0000, g}, {15'h0000, e}, what);
    endtask

    // Expected result bytes for level v, justify j and reduced mode b8.
    function automatic logic [15:0] exp_res(input logic [9:0] v,
            input logic j, input logic b8);
        if (b8) begin
            return {v[9:2], 8'h00};
        end
        return j ? {v, 6'h00} : {6'h00, v};
    endfunction

    // Pulses a source for one cycle; hit low picks one that must be ignored.
    task automatic fire_src(input logic [2:0] m, input logic hit);
        @(negedge mclk_i);
        case (m)
            `ACC_SM_SOFT: {busy_write_i, timer0_ovf_i} = {hit, !hit};
            `ACC_SM_TMR0: {timer0_ovf_i, busy_write_i} = {hit, !hit};
            `ACC_SM_TMR2: {timer2_lo_ovf_i, timer2_hi_ovf_i} =
                {hit ~^ timer2_split_i, hit ^ timer2_split_i};
            `ACC_SM_TMR1: {timer1_ovf_i, busy_write_i} = {hit, !hit};
            `ACC_SM_EXT: {external_start_input_i, busy_write_i} = {hit, !hit};
            `ACC_SM_TMR3: {timer3_lo_ovf_i, timer3_hi_ovf_i} =
                {hit ~^ timer3_split_i, hit ^ timer3_split_i};
            default: {busy_write_i, timer0_ovf_i, timer1_ovf_i,
                external_start_input_i} = 4'hF;
        endcase
        @(negedge mclk_i);
        {busy_write_i, timer0_ovf_i, timer1_ovf_i} = 3'h0;
        external_start_input_i = 1'b0;
        {timer2_lo_ovf_i, timer2_hi_ovf_i} = 2'h0;
        {timer3_lo_ovf_i, timer3_hi_ovf_i} = 2'h0;
    endtask

    // Runs one conversion of level v, then checks result, flags and irq.
    task automatic run_conv(input logic [2:0] m, input logic [4:0] d,
            input logic b8, input logic j, input logic [9:0] v,
            input logic ie, output int n);
        int k;
        logic [15:0] got;
        @(negedge mclk_i);
        {start_mode_select_i, conv_clock_divider_i} = {m, d};
        {eight_bit_mode_bit_i, left_justify_bit_i, int_enable_i} = {b8, j, ie};
        {timer2_split_i, timer3_split_i} = 2'($urandom);
        level = v;
        fire_src(m, 1'b0);
        repeat (4) @(negedge mclk_i);
        chk_bit(conversion_busy_bit_o, 1'b0, "stray start");
        fire_src(m, 1'b1);
        n = 0;
        k = 0;
        while (conversion_done_flag_o !== 1'b1 && k < 1000) begin
            if (stall && k == 5) begin
                ce_i = 1'b0;
                repeat (8) @(negedge mclk_i);
                ce_i = 1'b1;
            end
            n += (conversion_busy_bit_o === 1'b1);
            @(negedge mclk_i);
            k++;
        end
        got = {result_high_byte_o, result_low_byte_o};
        chk_val(got, exp_res(v, j, b8), "result");
        chk_bit(conversion_busy_bit_o, 1'b0, "busy after done");
        @(negedge mclk_i);
        chk_bit(irq_o, ie, "irq");
        repeat (3) @(negedge mclk_i);
        chk_bit(conversion_done_flag_o, 1'b1, "done held");
        done_clear_i = 1'b1;
        @(negedge mclk_i);
        done_clear_i = 1'b0;
        chk_bit(conversion_done_flag_o, 1'b0, "done cleared");
        @(negedge mclk_i);
        chk_bit(irq_o, 1'b0, "irq dropped");
        $display("test mode %0d level %h done", m, v);
    endtask

    // Prints the counts and the verdict, then stops.
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Reset, start codes 0 to 5 at full scale, unused codes 6 and 7, short mode, then random runs.
    initial begin
        {resetn_i, left_justify_bit_i, eight_bit_mode_bit_i} = 3'h0;
        {busy_write_i, done_clear_i, int_enable_i, timer0_ovf_i} = 4'h0;
        {timer1_ovf_i, timer2_lo_ovf_i, timer2_hi_ovf_i} = 3'h0;
        timer2_split_i = 1'b0;
        {timer3_lo_ovf_i, timer3_hi_ovf_i, timer3_split_i} = 3'h0;
        {external_start_input_i, start_mode_select_i} = 4'h0;
        conv_clock_divider_i = 5'h00;
        ce_i = 1'b1;
        void'($urandom(71898));
        repeat (5) @(negedge mclk_i);
        resetn_i = 1'b1;
        @(negedge mclk_i);
        chk_bit(conversion_busy_bit_o, 1'b0, "busy after reset");
        for (int m = 0; m < 6; m++) begin
            run_conv(m[2:0], 5'h01, 1'b0, m[0], 10'h3FF, 1'b1, len);
        end
        for (int m = 6; m < 8; m++) begin
            start_mode_select_i = m[2:0];
            fire_src(m[2:0], 1'b1);
            repeat (4) @(negedge mclk_i);
            chk_bit(conversion_busy_bit_o, 1'b0, "unused code");
        end
        $display("test unused codes done");
        run_conv(`ACC_SM_SOFT, 5'h07, 1'b0, 1'b0, 10'h200, 1'b0, len10);
        run_conv(`ACC_SM_SOFT, 5'h07, 1'b1, 1'b1, 10'h1FF, 1'b0, len8);
        chk_val(16'(len10 - len8), 16'h0010, "short mode");
        chk_bit(len10 + 2 <= 100, 1'b1, "throughput");
        for (int i = 0; i < 24; i++) begin
            stall = (i == 3);
            run_conv(3'($urandom_range(5, 0)), 5'($urandom_range(7, 0)),
                1'($urandom), 1'($urandom), 10'($urandom), 1'($urandom), len);
        end
        end_of_test();
    end
endmodule // tb_adc_conversion_control

// Attaches the port checker to every converter core.
bind acc_core acc_chk chk_u (.mclk_i, .resetn_i, .ce_i, .eight_bit_mode_bit_i,
    .conv_clock_divider_i, .start_mode_select_i, .busy_write_i, .done_clear_i,
    .int_enable_i, .timer0_ovf_i, .timer1_ovf_i, .timer2_lo_ovf_i,
    .timer2_hi_ovf_i, .timer2_split_i, .timer3_lo_ovf_i, .timer3_hi_ovf_i,
    .timer3_split_i, .external_start_input_i, .conversion_busy_bit_o,
    .conversion_done_flag_o, .irq_o, .result_high_byte_o, .result_low_byte_o);
